// ===== core/cdsb_bank.sv
`timescale 1ns/10ps
module cdsb_bank
   import cdsb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cdsb_pkg::ADDR_W-1:0] paddr,
   input wire logic [cdsb_pkg::DATA_W-1:0] pwdata,
   output logic [cdsb_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [cdsb_pkg::NCH-1:0] ch_active,
   input wire cdsb_pkg::cdsb_flags_s [cdsb_pkg::NCH-1:0] chan_evt,
   output logic common_fault_flag,
   output logic fault_n,
   output logic irq
);
   import cdsb_pkg::*;

   cdsb_apb_e state_r;
   logic pready_r;
   logic pslverr_r;
   logic [DATA_W-1:0] prdata_r;
   logic [7:0] diag_en_r;
   logic [7:0] collective_r;
   logic common_fault_r;
   logic fault_n_r;
   logic [7:0] irq_sts_r;
   logic [7:0] irq_mask_r;
   logic irq_r;
   logic [MODE_W-1:0] mode_r;

   logic [5:0] idx;
   logic legal;
   logic acc_start;
   logic taken;
   logic wr_taken;
   logic rd_taken;
   logic upd_p;
   logic [DATA_W-1:0] rd_mux;
   logic [7:0] col_nxt;
   logic [7:0] new_fault;
   cdsb_flags_s [NCH-1:0] qual;
   cdsb_flags_s [NCH-1:0] int_flags;
   cdsb_flags_s [NCH-1:0] vis_flags;

   // address decode; misaligned or unlisted addresses are refused
   assign idx = paddr[7:2];
   always_comb begin
      legal = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         unique case (idx)
            IDX_SUMMARY, IDX_GLOBAL, IDX_ENABLE: legal = 1'b1;
            IDX_IRQ_STS, IDX_IRQ_MASK, IDX_MODE: legal = 1'b1;
            default: legal = cdsb_is_diag(idx);
         endcase
      end
   end

   // one wait state: answer lands one cycle after the access phase starts
   assign acc_start = psel && penable && (state_r == ST_IDLE);
   assign taken = psel && penable && pready_r;
   assign wr_taken = taken && pwrite && !pslverr_r;
   assign rd_taken = taken && !pwrite && !pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_IDLE;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         state_r <= acc_start ? ST_ANSWER : ST_IDLE;
         pready_r <= acc_start;
         pslverr_r <= acc_start && !legal;
      end
   end

   // read mux; narrow registers sit in the low bits, the rest reads zero
   always_comb begin
      rd_mux = '0;
      unique case (idx)
         IDX_SUMMARY: rd_mux[7:0] = collective_r;
         IDX_GLOBAL: rd_mux[GLOBAL_CF_BIT] = common_fault_r;
         IDX_ENABLE: rd_mux[7:0] = diag_en_r;
         IDX_IRQ_STS: rd_mux[7:0] = irq_sts_r;
         IDX_IRQ_MASK: rd_mux[7:0] = irq_mask_r;
         IDX_MODE: rd_mux[MODE_W-1:0] = mode_r;
         default: begin
            if (cdsb_is_diag(idx)) begin
               rd_mux[FLAG_W-1:0] = vis_flags[cdsb_diag_ch(idx)];
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (acc_start) begin
         prdata_r <= (!pwrite && legal) ? rd_mux : '0;
      end
   end

   // enable register; channel registers have no write path at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diag_en_r <= ENABLE_RST;
      end else if (wr_taken && idx == IDX_ENABLE) begin
         diag_en_r <= pwdata[7:0];
      end
   end

   // access mode selects when the channel registers refresh
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_r <= MODE_RST;
      end else if (wr_taken && idx == IDX_MODE) begin
         mode_r <= pwdata[MODE_W-1:0];
      end
   end

   // refresh on a summary read, or on any access not refused in the two low modes
   assign upd_p = (rd_taken && idx == IDX_SUMMARY) ||
                  (taken && !pslverr_r && mode_r < MODE_AUTO_LIMIT);

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         cdsb_chan_diag u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .enable(diag_en_r[g]),
            .active(ch_active[g]),
            .evt(chan_evt[g]),
            .upd(upd_p),
            .qual(qual[g]),
            .int_flags(int_flags[g]),
            .vis_flags(vis_flags[g])
         );
         // led gating is masked out of the summary
         assign col_nxt[g] = diag_en_r[g] &&
                             |(int_flags[g] & SUMMARY_MASK);
         assign new_fault[g] = |(qual[g] & SUMMARY_MASK);
      end
   endgenerate

   // summary and pin trail the internal data by one and two cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         collective_r <= 8'h00;
         common_fault_r <= 1'b0;
         fault_n_r <= 1'b1;
      end else begin
         collective_r <= col_nxt;
         common_fault_r <= |collective_r;
         fault_n_r <= ~(|collective_r);
      end
   end

   // sticky interrupt status, write one to clear, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts_r <= 8'h00;
      end else begin
         if (wr_taken && idx == IDX_IRQ_STS) begin
            irq_sts_r <= (irq_sts_r & ~pwdata[7:0]) | new_fault;
         end else begin
            irq_sts_r <= irq_sts_r | new_fault;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_r <= MASK_RST;
      end else if (wr_taken && idx == IDX_IRQ_MASK) begin
         irq_mask_r <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_sts_r & irq_mask_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign common_fault_flag = common_fault_r;
   assign fault_n = fault_n_r;
   assign irq = irq_r;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [NCH*FLAG_W-1:0] int_flat;
   logic [NCH*FLAG_W-1:0] qual_flat;
   logic [NCH*FLAG_W-1:0] vis_flat;
   assign int_flat = int_flags;
   assign qual_flat = qual;
   assign vis_flat = vis_flags;

   property p_en_reset;
      $rose(presetn) |-> diag_en_r == ENABLE_RST;
   endproperty
   a_en_reset: assert property (p_en_reset) else $error("enable not all ones");

   property p_en_write;
      wr_taken && idx == IDX_ENABLE |=> diag_en_r == $past(pwdata[7:0]);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write lost");

   property p_dis_summary;
      !diag_en_r[0] ##1 !diag_en_r[0] |=> !collective_r[0];
   endproperty
   a_dis_summary: assert property (p_dis_summary) else $error("disabled ch0 in summary");

   property p_common;
      (|collective_r) |=> common_fault_r && !fault_n_r;
   endproperty
   a_common: assert property (p_common) else $error("common fault not raised");

   property p_led_only;
      int_flags[0] == 6'h20 |=> !collective_r[0];
   endproperty
   a_led_only: assert property (p_led_only) else $error("led gating in summary");

   property p_sticky;
      !upd_p && (diag_en_r == 8'hFF) |=> (($past(int_flat) & ~int_flat) == '0);
   endproperty
   a_sticky: assert property (p_sticky) else $error("sticky flag dropped");

   property p_clear_on_read;
      rd_taken && idx == IDX_SUMMARY && $stable(diag_en_r) |=>
         int_flat == $past(qual_flat) && vis_flat == $past(int_flat | qual_flat);
   endproperty
   a_clear_on_read: assert property (p_clear_on_read) else $error("summary read no update");

   property p_ro_diag;
      wr_taken && cdsb_is_diag(idx) && mode_r >= MODE_AUTO_LIMIT |=> $stable(vis_flat);
   endproperty
   a_ro_diag: assert property (p_ro_diag) else $error("channel register written");

   property p_reserved;
      pready_r && !pwrite && cdsb_is_diag(idx) |-> prdata_r[DATA_W-1:FLAG_W] == '0;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

   property p_ot_inactive;
      diag_en_r[0] && !ch_active[0] && !upd_p |=> int_flags[0].channel_overtemp_flag ==
         $past(int_flags[0].channel_overtemp_flag);
   endproperty
   a_ot_inactive: assert property (p_ot_inactive) else $error("overtemp while inactive");

   property p_answer;
      acc_start |=> pready_r ##1 !pready_r;
   endproperty
   a_answer: assert property (p_answer) else $error("apb answer timing");

   property p_irq;
      (|(irq_sts_r & irq_mask_r)) |=> irq_r;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not raised");

   // qualification watched on channels 0 and 1 only, to keep the list short
   property p_en_clear;
      !diag_en_r[0] |=> int_flags[0] == DIAG_RST;
   endproperty
   a_en_clear: assert property (p_en_clear) else $error("disabled channel kept data");

   property p_col_or;
      collective_r[0] == $past(diag_en_r[0] && (int_flags[0].short_to_supply_flag ||
         int_flags[0].overcurrent_limit_flag || int_flags[0].open_load_off_flag ||
         int_flags[0].open_load_on_flag || int_flags[0].channel_overtemp_flag));
   endproperty
   a_col_or: assert property (p_col_or) else $error("summary bit not the flag or");

   property p_no_fault;
      !(|collective_r) |=> !common_fault_r && fault_n_r;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault pin without summary");

   property p_vis_hold;
      !upd_p |=> $stable(vis_flat);
   endproperty
   a_vis_hold: assert property (p_vis_hold) else $error("channel image moved");

   property p_oc_set;
      diag_en_r[1] && ch_active[1] && chan_evt[1].overcurrent_limit_flag |=>
         int_flags[1].overcurrent_limit_flag;
   endproperty
   a_oc_set: assert property (p_oc_set) else $error("overcurrent not latched");

   property p_led_off;
      !ch_active[0] |=> !$rose(int_flags[0].led_gated_flag);
   endproperty
   a_led_off: assert property (p_led_off) else $error("led flag while off");

   property p_olo_on;
      ch_active[0] |=> !$rose(int_flags[0].open_load_off_flag);
   endproperty
   a_olo_on: assert property (p_olo_on) else $error("open load off flag while on");

   property p_ola_off;
      !ch_active[0] |=> !$rose(int_flags[0].open_load_on_flag);
   endproperty
   a_ola_off: assert property (p_ola_off) else $error("open load on flag while off");

   property p_scv_on;
      ch_active[0] |=> !$rose(int_flags[0].short_to_supply_flag);
   endproperty
   a_scv_on: assert property (p_scv_on) else $error("supply short flag while on");

   property p_auto_upd;
      taken && !pslverr_r && mode_r < MODE_AUTO_LIMIT |=> vis_flat == $past(int_flat | qual_flat);
   endproperty
   a_auto_upd: assert property (p_auto_upd) else $error("access did not refresh");

   property p_refuse;
      acc_start && !legal |=> pslverr_r && pready_r && prdata_r == '0;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad address not refused");

   c_col_read: cover property (rd_taken && idx == IDX_SUMMARY && |collective_r);
   c_en_write: cover property (wr_taken && idx == IDX_ENABLE);
   c_fault_pin: cover property ($fell(fault_n_r));
   c_irq: cover property ($rose(irq_r));
endmodule : cdsb_bank

// ===== core/cdsb_pkg.sv
package cdsb_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int NCH = 8;
   localparam int FLAG_W = 6;
   localparam int MODE_W = 3;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_SUMMARY = 6'h02;
   localparam logic [5:0] IDX_GLOBAL = 6'h04;
   localparam logic [5:0] IDX_ENABLE = 6'h06;
   localparam logic [5:0] IDX_CHANNEL0_DIAG_FLAGS = 6'h08;
   localparam logic [5:0] IDX_DIAG_LAST = 6'h16;
   localparam logic [5:0] IDX_IRQ_STS = 6'h18;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h19;
   localparam logic [5:0] IDX_MODE = 6'h1A;

   // reset values
   localparam logic [7:0] ENABLE_RST = 8'hFF;
   localparam logic [FLAG_W-1:0] DIAG_RST = 6'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RST = 3'h4;

   // modes below this value refresh the channel registers on every access that is not refused
   localparam logic [MODE_W-1:0] MODE_AUTO_LIMIT = 3'h2;

   // flag positions inside a channel register
   localparam int BIT_OVERTEMP = 0;
   localparam int BIT_OPEN_OFF = 1;
   localparam int BIT_OPEN_ON = 2;
   localparam int BIT_OVERCURRENT = 3;
   localparam int BIT_SHORT_SUPPLY = 4;
   localparam int BIT_LED_GATED = 5;
   localparam int GLOBAL_CF_BIT = 0;
   // flags that count toward the collective summary, led gating left out
   localparam logic [FLAG_W-1:0] SUMMARY_MASK = 6'h1F;

   typedef struct packed {
      logic led_gated_flag;
      logic short_to_supply_flag;
      logic overcurrent_limit_flag;
      logic open_load_on_flag;
      logic open_load_off_flag;
      logic channel_overtemp_flag;
   } cdsb_flags_s;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ANSWER = 1'b1
   } cdsb_apb_e;

   // true when an index selects one of the channel registers
   function automatic logic cdsb_is_diag(input logic [5:0] idx);
      return (idx >= IDX_CHANNEL0_DIAG_FLAGS) && (idx <= IDX_DIAG_LAST) && !idx[0];
   endfunction : cdsb_is_diag

   // channel number of a channel register index
   function automatic logic [2:0] cdsb_diag_ch(input logic [5:0] idx);
      logic [5:0] rel;
      rel = idx - IDX_CHANNEL0_DIAG_FLAGS;
      return rel[3:1];
   endfunction : cdsb_diag_ch
endpackage : cdsb_pkg

// ===== core/cdsb_chan_diag.sv
`timescale 1ns/10ps
module cdsb_chan_diag
   import cdsb_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic active,
   input wire cdsb_pkg::cdsb_flags_s evt,
   input wire logic upd,
   output cdsb_pkg::cdsb_flags_s qual,
   output cdsb_pkg::cdsb_flags_s int_flags,
   output cdsb_pkg::cdsb_flags_s vis_flags
);
   cdsb_flags_s int_r;
   cdsb_flags_s vis_r;

   // qualify raw detections by enable and by the output state
   always_comb begin
      qual = '0;
      if (enable) begin
         qual.channel_overtemp_flag = active && evt.channel_overtemp_flag;
         qual.open_load_off_flag = !active && evt.open_load_off_flag;
         qual.open_load_on_flag = active && evt.open_load_on_flag;
         qual.overcurrent_limit_flag = active && evt.overcurrent_limit_flag;
         qual.short_to_supply_flag = !active && evt.short_to_supply_flag;
         qual.led_gated_flag = active && evt.led_gated_flag;
      end
   end

   // internal sticky data; a detection in the clearing cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_r <= DIAG_RST;
      end else if (!enable) begin
         int_r <= DIAG_RST;
      end else if (upd) begin
         int_r <= qual;
      end else begin
         int_r <= int_r | qual;
      end
   end

   // visible copy only moves on an update, so software sees a stable image
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vis_r <= DIAG_RST;
      end else if (upd) begin
         vis_r <= int_r | qual;
      end
   end

   assign int_flags = int_r;
   assign vis_flags = vis_r;
endmodule : cdsb_chan_diag

// ===== bench/cdsb_host.sv
`timescale 1ns/10ps
// apb master standing in for the host controller
module cdsb_host
   import cdsb_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [cdsb_pkg::ADDR_W-1:0] paddr,
   output logic [cdsb_pkg::DATA_W-1:0] pwdata,
   input wire logic [cdsb_pkg::DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end

   // request held until pready is seen high at an edge; no fixed latency assumed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : cdsb_host

// ===== bench/channel_diag_status_bank_tb.sv
`timescale 1ns/10ps
module channel_diag_status_bank_tb;
   import cdsb_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cff, fault_n, irq;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [NCH-1:0] act_i;
   cdsb_flags_s [NCH-1:0] evt_i;
   int err_total, total_checks;
   logic [5:0] acc [8];
   logic [5:0] vis [8];
   logic [7:0] en, msk, sts;
   logic [2:0] mode;

   cdsb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ch_active(act_i), .chan_evt(evt_i),
      .common_fault_flag(cff), .fault_n(fault_n), .irq(irq));
   cdsb_host h (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // model of the collective summary, led gating left out
   function automatic logic [7:0] summ();
      for (int c = 0; c < 8; c++) summ[c] = |(acc[c] & SUMMARY_MASK);
   endfunction : summ

   // channel registers take the sticky data, which then restarts empty
   function automatic void upd();
      for (int c = 0; c < 8; c++) begin
         vis[c] = acc[c];
         acc[c] = '0;
      end
   endfunction : upd

   function automatic logic [7:0] mval(input logic [5:0] idx);
      case (idx)
         IDX_SUMMARY: return summ();
         IDX_GLOBAL: return {7'h00, |summ()};
         IDX_ENABLE: return en;
         IDX_IRQ_STS: return sts;
         IDX_IRQ_MASK: return msk;
         IDX_MODE: return {5'h00, mode};
         default: return {2'b00, vis[3'((idx - IDX_CHANNEL0_DIAG_FLAGS) >> 1)]};
      endcase
   endfunction : mval

   // mapped access; the update mode is judged before a mode write lands
   task automatic rw(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      logic err;
      h.xfer(wr, {idx, 2'b00}, wd, rd, err);
      chk("pslverr", 32'h0, {31'h0, err});
      if ((!wr && idx == IDX_SUMMARY) || mode < MODE_AUTO_LIMIT) upd();
      if (wr) begin
         case (idx)
            IDX_ENABLE: begin
               en = wd[7:0];
               for (int c = 0; c < 8; c++) if (!en[c]) acc[c] = '0;
            end
            IDX_IRQ_MASK: msk = wd[7:0];
            IDX_IRQ_STS: sts &= ~wd[7:0];
            IDX_MODE: mode = wd[2:0];
            default: ;
         endcase
      end
   endtask : rw

   task automatic rdchk(input logic [5:0] idx);
      logic [7:0] e;
      e = mval(idx);
      rw(1'b0, idx, 32'h0);
      chk($sformatf("reg %h", idx), {24'h0, e}, {24'h0, rd[7:0]});
   endtask : rdchk

   // only events matching the output state and enable are kept
   task automatic inj(input int c, input logic a, input logic [5:0] e);
      logic [5:0] q;
      q = e & (a ? 6'h2D : 6'h12);
      if (en[c]) begin
         acc[c] |= q;
         if (|(q & SUMMARY_MASK)) sts[c] = 1'b1;
      end
      @(posedge pclk);
      act_i[c] <= a;
      evt_i[c] <= cdsb_flags_s'(e);
      @(posedge pclk);
      evt_i <= '0;
      repeat (4) @(posedge pclk);
   endtask : inj

   task automatic pins();
      repeat (4) @(posedge pclk);
      chk("cff", {31'h0, |summ()}, {31'h0, cff});
      chk("fault_n", {31'h0, ~|summ()}, {31'h0, fault_n});
      chk("irq", {31'h0, |(sts & msk)}, {31'h0, irq});
   endtask : pins

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   initial begin
      #50000;
      err_total++;
      results();
   end

   initial begin
      logic err;
      presetn = 1'b0;
      act_i = '0;
      evt_i = '0;
      err_total = 0;
      total_checks = 0;
      en = ENABLE_RST;
      msk = MASK_RST;
      sts = '0;
      mode = MODE_RST;
      for (int c = 0; c < 8; c++) {acc[c], vis[c]} = '0;
      void'($urandom(32'hdcd07a81));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      pins();
      // reset image of every register, low byte only, reserved bits above it not compared
      for (int i = 2; i <= 26; i += 2) rdchk(6'(i));
      rdchk(IDX_IRQ_MASK);
      $display("test reset done");
      // channel registers ignore writes; enable reads back
      for (int c = 0; c < 8; c++) rw(1'b1, IDX_CHANNEL0_DIAG_FLAGS + 6'(2 * c), $urandom);
      for (int c = 0; c < 8; c++) rdchk(IDX_CHANNEL0_DIAG_FLAGS + 6'(2 * c));
      repeat (3) begin
         rw(1'b1, IDX_ENABLE, $urandom);
         rdchk(IDX_ENABLE);
      end
      h.xfer(1'b0, 8'h0C, 32'h0, rd, err);
      chk("unmapped", 32'h1, {31'h0, err});
      h.xfer(1'b1, 8'h19, 32'h0, rd, err);
      chk("misaligned", 32'h1, {31'h0, err});
      rdchk(IDX_ENABLE);
      $display("test access done");
      // random faults, enable changed midway, then a summary read
      rw(1'b1, IDX_ENABLE, 32'hFF);
      for (int i = 0; i < 24; i++) begin
         if (i == 12) rw(1'b1, IDX_ENABLE, $urandom);
         inj($urandom % 8, 1'($urandom), 6'($urandom));
      end
      pins();
      rdchk(IDX_GLOBAL);
      rdchk(IDX_SUMMARY);
      for (int c = 0; c < 8; c++) rdchk(IDX_CHANNEL0_DIAG_FLAGS + 6'(2 * c));
      pins();
      rdchk(IDX_SUMMARY);
      for (int c = 0; c < 8; c++) rdchk(IDX_CHANNEL0_DIAG_FLAGS + 6'(2 * c));
      $display("test faults done");
      // interrupt raised, masked, cleared
      rw(1'b1, IDX_ENABLE, 32'hFF);
      inj(2, 1'b0, 6'h10);
      rw(1'b1, IDX_IRQ_MASK, 32'h00);
      pins();
      rw(1'b1, IDX_IRQ_MASK, 32'hFF);
      pins();
      rdchk(IDX_IRQ_STS);
      rw(1'b1, IDX_IRQ_STS, 32'hFF);
      pins();
      rdchk(IDX_IRQ_STS);
      $display("test irq done");
      // update on every access only in the low modes
      for (int m = 3; m >= 0; m--) begin
         rw(1'b1, IDX_MODE, 32'(m));
         inj(1, 1'b1, 6'h08);
         rdchk(IDX_ENABLE);
         rdchk(IDX_CHANNEL0_DIAG_FLAGS + 6'h02);
         rdchk(IDX_SUMMARY);
      end
      $display("test modes done");
      // led gating alone raises no summary bit but is kept
      rw(1'b1, IDX_MODE, {29'h0, MODE_RST});
      inj(0, 1'b1, 6'h20);
      pins();
      rdchk(IDX_SUMMARY);
      rdchk(IDX_CHANNEL0_DIAG_FLAGS);
      $display("test led done");
      results();
   end
endmodule : channel_diag_status_bank_tb
